// ==== src/tlic_pkg.sv ====
/*
  Package of the two-level interrupt controller: register offsets, field
  positions, reset values, source order and vectors.
  Assumes a 32-bit APB register bus with one aligned word per register.
*/
package tlic_pkg;

  // ---------------------------------------------------------------
  // Sources and order
  // ---------------------------------------------------------------
  localparam int N_SRC = 11;
  localparam int SRC_W = 4;
  typedef logic [SRC_W-1:0] tlic_src_t;

  localparam tlic_src_t SRC_EXT0 = 4'h0;
  localparam tlic_src_t SRC_TMR0 = 4'h1;
  localparam tlic_src_t SRC_EXT1 = 4'h2;
  localparam tlic_src_t SRC_TMR1 = 4'h3;
  localparam tlic_src_t SRC_SER = 4'h4;
  localparam tlic_src_t SRC_EXT2 = 4'h5;
  localparam tlic_src_t SRC_EXT3 = 4'h6;
  localparam tlic_src_t SRC_CID = 4'h7;
  localparam tlic_src_t SRC_DIV = 4'h8;
  localparam tlic_src_t SRC_COMP = 4'h9;
  localparam tlic_src_t SRC_WDT = 4'hA;

  // Vector per source, index 0 is highest
  localparam logic [7:0] VEC_TABLE [N_SRC] = '{
    8'h03, 8'h0B, 8'h13, 8'h1B, 8'h3B, 8'h43, 8'h4B, 8'h53, 8'h5B, 8'h63, 8'h6B
  };

  // Flags cleared by hardware when vectored (caller-id and watchdog are not)
  localparam logic [N_SRC-1:0] HW_CLR_MASK = 11'h37F;

  // ---------------------------------------------------------------
  // Register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_PRIMARY_EN = 8'h00;
  localparam logic [7:0] OFF_EXT_EN = 8'h04;
  localparam logic [7:0] OFF_PRIORITY = 8'h08;
  localparam logic [7:0] OFF_TIMER_CTRL = 8'h0C;
  localparam logic [7:0] OFF_EXT_FLAG = 8'h10;
  localparam logic [7:0] OFF_WDT_CTRL = 8'h14;
  localparam logic [7:0] OFF_SER_CTRL = 8'h18;
  localparam logic [7:0] OFF_CID_FLAGS = 8'h1C;
  localparam logic [7:0] OFF_STATUS = 8'h20;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int PE_GLOBAL = 7;
  localparam int PE_SERIAL = 6;
  localparam int TC_TT0 = 0;
  localparam int TC_EXT0 = 1;
  localparam int TC_TT1 = 2;
  localparam int TC_EXT1 = 3;
  localparam int TC_TMR0 = 5;
  localparam int TC_TMR1 = 7;
  localparam int XF_EXT2 = 0;
  localparam int XF_EXT3 = 1;
  localparam int XF_CID = 2;
  localparam int XF_DIV = 3;
  localparam int XF_COMP = 4;
  localparam int WC_WDT = 3;
  localparam int SC_SER = 7;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_PRIMARY_EN = 8'h00;
  localparam logic [5:0] RST_EXT_EN = 6'h00;
  localparam logic [N_SRC-1:0] RST_PRIORITY = 11'h000;
  localparam logic [1:0] RST_TRIG = 2'h0;
  localparam logic [N_SRC-1:0] RST_FLAGS = 11'h000;
  localparam logic [3:0] RST_PINS = 4'hF;

endpackage

// ==== src/tlic_ctrl.sv ====
/*
  Two-level interrupt controller: request flags, enables, priority
  resolution, vectoring and in-service tracking, with an APB register slave.
  Assumes every pclk edge is one machine cycle and the core reports the
  last cycle of each instruction, blocking instructions and returns.
*/
`timescale 1ns/1ps

module tlic_ctrl
  import tlic_pkg::*;
#(
  parameter int CID_N = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_req_pin_zero,
  input wire logic ext_req_pin_one,
  input wire logic ext_req_pin_two,
  input wire logic ext_req_pin_three,
  input wire logic timer_zero_overflow,
  input wire logic timer_one_overflow,
  input wire logic serial_event,
  input wire logic divider_overflow,
  input wire logic comparator_result_bit,
  input wire logic watchdog_timeout,
  input wire logic [CID_N-1:0] cid_set,
  input wire logic last_cycle,
  input wire logic no_vector_instr,
  input wire logic reti,
  output logic vec_valid,
  output logic [7:0] vec_addr,
  output logic in_service_high,
  output logic in_service_low
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Lowest index wins: index 0 is the highest rank
  function automatic tlic_src_t first_set(input logic [N_SRC-1:0] v);
    tlic_src_t idx;
    idx = '0;
    for (int i = N_SRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = SRC_W'(i);
      end
    end
    return idx;
  endfunction

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic [7:0] primary_enable_reg_q;
  logic [5:0] extended_enable_reg_q;
  logic [N_SRC-1:0] prio_q;
  logic [1:0] trig_q;
  logic [N_SRC-1:0] flag_q;
  logic [N_SRC-1:0] flag_d;
  logic [CID_N-1:0] cid_q;
  logic [3:0] pin_q;
  logic [3:0] pin_prev_q;
  logic comp_prev_q;
  logic in_hi_q;
  logic in_lo_q;
  logic vec_valid_q;
  logic [7:0] vec_addr_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;

  logic wr_en;
  logic rd_en;
  logic [N_SRC-1:0] hw_set;
  logic [N_SRC-1:0] sw_we;
  logic [N_SRC-1:0] sw_val;
  logic [N_SRC-1:0] req;
  logic [N_SRC-1:0] enable;
  logic [N_SRC-1:0] pend;
  logic [N_SRC-1:0] pend_hi;
  logic [N_SRC-1:0] pend_lo;
  logic [N_SRC-1:0] vec_clr;
  logic [3:0] fall;
  logic take;
  logic take_hi;
  tlic_src_t win;

  // ---------------------------------------------------------------
  // APB slave: one wait state, read captured in the wait cycle, write in the pready cycle
  // ---------------------------------------------------------------
  assign wr_en = psel & penable & pready_q & pwrite;
  assign rd_en = psel & penable & ~pready_q & ~pwrite;

  function automatic logic mapped(input logic [7:0] a);
    return (a == OFF_PRIMARY_EN) || (a == OFF_EXT_EN) || (a == OFF_PRIORITY) ||
           (a == OFF_TIMER_CTRL) || (a == OFF_EXT_FLAG) || (a == OFF_WDT_CTRL) ||
           (a == OFF_SER_CTRL) || (a == OFF_CID_FLAGS) || (a == OFF_STATUS);
  endfunction

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= psel & penable & ~pready_q;
      pslverr_q <= psel & penable & ~pready_q & ~mapped(paddr);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (rd_en) begin
      unique case (paddr)
        OFF_PRIMARY_EN: prdata_q <= {24'h000000, primary_enable_reg_q};
        OFF_EXT_EN: prdata_q <= {26'h0000000, extended_enable_reg_q};
        OFF_PRIORITY: prdata_q <= {21'h000000, prio_q};
        OFF_TIMER_CTRL: prdata_q <= {24'h000000, flag_q[SRC_TMR1], 1'b0,
          flag_q[SRC_TMR0], 1'b0, flag_q[SRC_EXT1], trig_q[1], flag_q[SRC_EXT0], trig_q[0]};
        OFF_EXT_FLAG: prdata_q <= {27'h0000000, req[SRC_COMP], req[SRC_DIV],
          req[SRC_CID], req[SRC_EXT3], req[SRC_EXT2]};
        OFF_WDT_CTRL: prdata_q <= {24'h000000, 4'h0, flag_q[SRC_WDT], 3'h0};
        OFF_SER_CTRL: prdata_q <= {24'h000000, flag_q[SRC_SER], 7'h00};
        OFF_CID_FLAGS: prdata_q <= {{(32-CID_N){1'b0}}, cid_q};
        OFF_STATUS: prdata_q <= {21'h000000, comparator_result_bit, vec_addr_q,
          in_hi_q, in_lo_q};
        default: prdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      primary_enable_reg_q <= RST_PRIMARY_EN;
      extended_enable_reg_q <= RST_EXT_EN;
      prio_q <= RST_PRIORITY;
      trig_q <= RST_TRIG;
    end else if (wr_en) begin
      if (paddr == OFF_PRIMARY_EN) begin
        primary_enable_reg_q <= pwdata[7:0] & 8'hCF;
      end
      if (paddr == OFF_EXT_EN) begin
        extended_enable_reg_q <= pwdata[5:0];
      end
      if (paddr == OFF_PRIORITY) begin
        prio_q <= pwdata[N_SRC-1:0];
      end
      if (paddr == OFF_TIMER_CTRL) begin
        trig_q <= {pwdata[TC_TT1], pwdata[TC_TT0]};
      end
    end
  end

  // Enable per source in source order
  assign enable = {extended_enable_reg_q,
                   primary_enable_reg_q[PE_SERIAL],
                   primary_enable_reg_q[3:0]};

  // ---------------------------------------------------------------
  // Input sampling
  // ---------------------------------------------------------------
  // Pins reset to idle high, so a pin already low at release is taken as an edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_q <= RST_PINS;
      pin_prev_q <= RST_PINS;
      comp_prev_q <= 1'b0;
    end else begin
      pin_q <= {ext_req_pin_three, ext_req_pin_two, ext_req_pin_one, ext_req_pin_zero};
      pin_prev_q <= pin_q;
      comp_prev_q <= comparator_result_bit;
    end
  end

  assign fall = pin_prev_q & ~pin_q;

  // ---------------------------------------------------------------
  // Flags
  // ---------------------------------------------------------------
  always_comb begin
    hw_set = '0;
    hw_set[SRC_EXT0] = fall[0] & trig_q[0];
    hw_set[SRC_TMR0] = timer_zero_overflow;
    hw_set[SRC_EXT1] = fall[1] & trig_q[1];
    hw_set[SRC_TMR1] = timer_one_overflow;
    hw_set[SRC_SER] = serial_event;
    hw_set[SRC_EXT2] = fall[2];
    hw_set[SRC_EXT3] = fall[3];
    hw_set[SRC_DIV] = divider_overflow;
    hw_set[SRC_COMP] = comparator_result_bit & ~comp_prev_q;
    hw_set[SRC_WDT] = watchdog_timeout;
  end

  always_comb begin
    sw_we = '0;
    sw_val = '0;
    if (wr_en && paddr == OFF_TIMER_CTRL) begin
      sw_we[SRC_EXT0] = 1'b1;
      sw_we[SRC_TMR0] = 1'b1;
      sw_we[SRC_EXT1] = 1'b1;
      sw_we[SRC_TMR1] = 1'b1;
      sw_val[SRC_EXT0] = pwdata[TC_EXT0];
      sw_val[SRC_TMR0] = pwdata[TC_TMR0];
      sw_val[SRC_EXT1] = pwdata[TC_EXT1];
      sw_val[SRC_TMR1] = pwdata[TC_TMR1];
    end
    if (wr_en && paddr == OFF_EXT_FLAG) begin
      sw_we[SRC_EXT2] = 1'b1;
      sw_we[SRC_EXT3] = 1'b1;
      sw_we[SRC_DIV] = 1'b1;
      sw_we[SRC_COMP] = 1'b1;
      sw_val[SRC_EXT2] = pwdata[XF_EXT2];
      sw_val[SRC_EXT3] = pwdata[XF_EXT3];
      sw_val[SRC_DIV] = pwdata[XF_DIV];
      sw_val[SRC_COMP] = pwdata[XF_COMP];
    end
    if (wr_en && paddr == OFF_WDT_CTRL) begin
      sw_we[SRC_WDT] = 1'b1;
      sw_val[SRC_WDT] = pwdata[WC_WDT];
    end
    if (wr_en && paddr == OFF_SER_CTRL) begin
      sw_we[SRC_SER] = 1'b1;
      sw_val[SRC_SER] = pwdata[SC_SER];
    end
  end

  // Hardware set beats both software write and vector clear
  always_comb begin
    for (int i = 0; i < N_SRC; i++) begin
      if (hw_set[i]) begin
        flag_d[i] = 1'b1;
      end else if (sw_we[i]) begin
        flag_d[i] = sw_val[i];
      end else begin
        flag_d[i] = flag_q[i] & ~vec_clr[i];
      end
    end
    // Level mode follows the pin; vectoring leaves it alone
    if (!trig_q[0]) begin
      flag_d[SRC_EXT0] = ~pin_q[0];
    end
    if (!trig_q[1]) begin
      flag_d[SRC_EXT1] = ~pin_q[1];
    end
    flag_d[SRC_CID] = 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_q <= RST_FLAGS;
    end else begin
      flag_q <= flag_d;
    end
  end

  // Caller-id flags: write one to clear, a new set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cid_q <= '0;
    end else if (wr_en && paddr == OFF_CID_FLAGS) begin
      cid_q <= cid_set | (cid_q & ~pwdata[CID_N-1:0]);
    end else begin
      cid_q <= cid_q | cid_set;
    end
  end

  always_comb begin
    req = flag_q;
    req[SRC_CID] = |cid_q;
  end

  // ---------------------------------------------------------------
  // Priority resolution and vectoring
  // ---------------------------------------------------------------
  // Current flags only: a denied request leaves no trace
  assign pend = req & enable & {N_SRC{primary_enable_reg_q[PE_GLOBAL]}};
  assign pend_hi = pend & prio_q;
  assign pend_lo = pend & ~prio_q;
  assign take_hi = (|pend_hi) & ~in_hi_q;
  assign take = last_cycle & ~no_vector_instr & ~reti &
                (take_hi | ((|pend_lo) & ~in_hi_q & ~in_lo_q));
  assign win = take_hi ? first_set(pend_hi) : first_set(pend_lo);

  always_comb begin
    vec_clr = '0;
    if (take) begin
      vec_clr[win] = HW_CLR_MASK[win];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vec_valid_q <= 1'b0;
      vec_addr_q <= 8'h00;
    end else begin
      vec_valid_q <= take;
      if (take) begin
        vec_addr_q <= VEC_TABLE[win];
      end
    end
  end

  // Return releases the higher level first; plain returns never reach here
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_hi_q <= 1'b0;
      in_lo_q <= 1'b0;
    end else if (take) begin
      if (take_hi) begin
        in_hi_q <= 1'b1;
      end else begin
        in_lo_q <= 1'b1;
      end
    end else if (reti) begin
      if (in_hi_q) begin
        in_hi_q <= 1'b0;
      end else begin
        in_lo_q <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign vec_valid = vec_valid_q;
  assign vec_addr = vec_addr_q;
  assign in_service_high = in_hi_q;
  assign in_service_low = in_lo_q;

endmodule // tlic_ctrl

// ==== bench/tlic_ctrl_checker.sv ====
/*
  Port checker for the interrupt controller: bus answer timing, vector
  conditions and in-service tracking.
  Assumes it is bound to tlic_ctrl and pclk is the only clock.
*/
`timescale 1ns/1ps
module tlic_ctrl_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic last_cycle,
  input wire logic no_vector_instr,
  input wire logic reti,
  input wire logic vec_valid,
  input wire logic [7:0] vec_addr,
  input wire logic in_service_high,
  input wire logic in_service_low
);
  // ----------
  // Properties
  // ----------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_wait;
    psel && penable && !pready;
  endsequence
  sequence s_low_taken;
    vec_valid && $past(in_service_low);
  endsequence
  AST_APB_LATENCY: assert property (s_setup |=> s_wait ##1 pready)
    else $error("pready not in second access cycle");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("pready held beyond one cycle");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready && psel && penable)
    else $error("pslverr outside a completing access");
  AST_VEC_CAUSE: assert property (
    vec_valid |-> $past(last_cycle && !no_vector_instr && !reti))
    else $error("vector outside an allowed cycle");
  AST_VEC_MARKS: assert property (vec_valid |-> in_service_high || in_service_low)
    else $error("vector without in-service level");
  AST_HIGH_BLOCKS: assert property (vec_valid |-> !$past(in_service_high))
    else $error("vector while high level in service");
  AST_LOW_PREEMPT: assert property (s_low_taken |-> $rose(in_service_high))
    else $error("low service preempted by low request");
  AST_VEC_TABLE: assert property (
    vec_valid |-> vec_addr inside {8'h03, 8'h0B, 8'h13, 8'h1B, 8'h3B, 8'h43, 8'h4B,
      8'h53, 8'h5B, 8'h63, 8'h6B})
    else $error("vector address outside the table");
  AST_HIGH_HELD: assert property (in_service_high && !reti |=> in_service_high)
    else $error("high level released without return");
  AST_RETI_HIGH: assert property (reti && in_service_high |=> !in_service_high)
    else $error("return did not release high level");
  AST_RETI_LOW: assert property (
    reti && !in_service_high && in_service_low |=> !in_service_low)
    else $error("return did not release low level");
  AST_ADDR_HOLDS: assert property (!vec_valid |-> $stable(vec_addr))
    else $error("vector address moved without a call");
endmodule // tlic_ctrl_checker

bind tlic_ctrl tlic_ctrl_checker u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .last_cycle(last_cycle), .no_vector_instr(no_vector_instr),
  .reti(reti), .vec_valid(vec_valid), .vec_addr(vec_addr),
  .in_service_high(in_service_high), .in_service_low(in_service_low)
);

// ==== bench/tlic_core_model.sv ====
/*
  Core model: instruction timing, blocking instructions and returns.
  Assumes the bench sets instruction length and raises return requests.
*/
`timescale 1ns/1ps
module tlic_core_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [2:0] instr_len,
  input wire logic blk_req,
  input wire logic ret_req,
  output logic last_cycle,
  output logic no_vector_instr,
  output logic reti
);
  // ----------
  // Sequencing
  // ----------
  logic [2:0] cnt_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 3'h0;
    end else if (last_cycle) begin
      cnt_q <= 3'h0;
    end else begin
      cnt_q <= cnt_q + 3'h1;
    end
  end
  // Long instructions make the controller wait for the last cycle
  assign last_cycle = presetn && (cnt_q >= instr_len - 3'h1);
  assign no_vector_instr = last_cycle && blk_req;
  // Return only ends on a last cycle, as a real core would
  assign reti = last_cycle && ret_req;
endmodule // tlic_core_model

// ==== bench/two_level_interrupt_controller_tb_top.sv ====
/*
  Self-checking bench: source table, then reset, priority and mode cases.
  Assumes tlic_ctrl with its checker bound and the core model beside it.
*/
`timescale 1ns/1ps
module two_level_interrupt_controller_tb_top;
  import tlic_pkg::*;
  typedef struct packed {
    tlic_src_t src;
    logic [7:0] vec;
    logic [7:0] foff;
    logic [4:0] fbit;
    logic kept;
    logic [7:0] coff;
    logic [7:0] cval;
  } tlic_row_t;
  // ----------
  // Signals
  // ----------
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, comp;
  logic [7:0] paddr, vec_addr, cid_v;
  logic [31:0] pwdata, prdata, rd_v;
  logic [3:0] pin_n;
  logic [10:0] ev;
  logic [2:0] instr_len;
  logic last_cycle, no_vector_instr, reti, vec_valid, in_service_high, in_service_low;
  logic blk_req, ret_req, er_v;
  int errors, compares;
  tlic_row_t rows [11] = '{
    '{4'h0, 8'h03, OFF_TIMER_CTRL, 5'h1, 1'b0, 8'h00, 8'h00},
    '{4'h1, 8'h0B, OFF_TIMER_CTRL, 5'h5, 1'b0, 8'h00, 8'h00},
    '{4'h2, 8'h13, OFF_TIMER_CTRL, 5'h3, 1'b0, 8'h00, 8'h00},
    '{4'h3, 8'h1B, OFF_TIMER_CTRL, 5'h7, 1'b0, 8'h00, 8'h00},
    '{4'h4, 8'h3B, OFF_SER_CTRL, 5'h7, 1'b0, 8'h00, 8'h00},
    '{4'h5, 8'h43, OFF_EXT_FLAG, 5'h0, 1'b0, 8'h00, 8'h00},
    '{4'h6, 8'h4B, OFF_EXT_FLAG, 5'h1, 1'b0, 8'h00, 8'h00},
    '{4'h7, 8'h53, OFF_EXT_FLAG, 5'h2, 1'b1, OFF_CID_FLAGS, 8'hFF},
    '{4'h8, 8'h5B, OFF_EXT_FLAG, 5'h3, 1'b0, 8'h00, 8'h00},
    '{4'h9, 8'h63, OFF_EXT_FLAG, 5'h4, 1'b0, 8'h00, 8'h00},
    '{4'hA, 8'h6B, OFF_WDT_CTRL, 5'h3, 1'b1, OFF_WDT_CTRL, 8'h00}};
  assign cid_v = {8{ev[7]}};
  tlic_ctrl dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_req_pin_zero(pin_n[0]), .ext_req_pin_one(pin_n[1]), .ext_req_pin_two(pin_n[2]),
    .ext_req_pin_three(pin_n[3]), .timer_zero_overflow(ev[1]), .timer_one_overflow(ev[3]),
    .serial_event(ev[4]), .divider_overflow(ev[8]), .comparator_result_bit(comp),
    .watchdog_timeout(ev[10]), .cid_set(cid_v), .last_cycle(last_cycle),
    .no_vector_instr(no_vector_instr), .reti(reti), .vec_valid(vec_valid),
    .vec_addr(vec_addr), .in_service_high(in_service_high), .in_service_low(in_service_low)
  );
  tlic_core_model u_core (
    .pclk(pclk), .presetn(presetn), .instr_len(instr_len), .blk_req(blk_req),
    .ret_req(ret_req), .last_cycle(last_cycle), .no_vector_instr(no_vector_instr),
    .reti(reti)
  );
  // ----------
  // Tasks
  // ----------
  task automatic summarize();
    if (errors == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bound(input int n, input int lim);
    if (n >= lim) begin
      errors++;
      summarize();
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
      bound(n, 20);
    end while (pready !== 1'b1);
    rd_v = prdata;
    er_v = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Pins fall and stay low; pulses last one cycle
  task automatic fire(input logic [10:0] m);
    pin_n <= pin_n & ~{m[6], m[5], m[2], m[0]};
    comp <= comp | m[9];
    ev <= m;
    @(posedge pclk);
    ev <= 11'h000;
  endtask
  task automatic wait_vec(input logic [7:0] exp);
    int n;
    n = 0;
    while (vec_valid !== 1'b1) begin
      @(posedge pclk);
      n++;
      bound(n, 60);
    end
    chk(vec_addr, exp);
  endtask
  task automatic expect_none(input int k);
    repeat (k) begin
      @(posedge pclk);
      chk(vec_valid, 1'b0);
    end
  endtask
  task automatic do_reti();
    int n;
    n = 0;
    ret_req <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
      bound(n, 20);
    end while (reti !== 1'b1);
    ret_req <= 1'b0;
    @(posedge pclk);
  endtask
  // ----------
  // Sequence
  // ----------
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  initial begin
    {presetn, psel, penable, pwrite, comp, blk_req, ret_req, er_v} = 8'h00;
    {paddr, pwdata, rd_v, ev} = '0;
    pin_n = 4'hF;
    instr_len = 3'h1;
    errors = 0;
    compares = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (logic [7:0] a = 8'h00; a <= 8'h20; a += 8'h04) begin
      apb(1'b0, a, 32'h0);
      chk(rd_v, 32'h0);
    end
    apb(1'b0, 8'h40, 32'h0);
    chk(rd_v, 32'h0);
    chk(er_v, 1'b1);
    apb(1'b1, OFF_PRIMARY_EN, 32'hFF);
    apb(1'b0, OFF_PRIMARY_EN, 32'h0);
    chk(rd_v, 32'hCF);
    apb(1'b1, OFF_EXT_EN, 32'h3F);
    apb(1'b1, OFF_TIMER_CTRL, 32'h05);
    instr_len <= 3'h3;
    foreach (rows[i]) begin
      fire(11'h001 << rows[i].src);
      wait_vec(rows[i].vec);
      chk(in_service_low, 1'b1);
      apb(1'b0, rows[i].foff, 32'h0);
      chk(rd_v[rows[i].fbit], rows[i].kept);
      if (rows[i].kept) apb(1'b1, rows[i].coff, {24'h0, rows[i].cval});
      do_reti();
      expect_none(4);
      pin_n <= 4'hF;
      comp <= 1'b0;
      repeat (2) @(posedge pclk);
    end
    // Divider and watchdog enables off: flags set, no call
    apb(1'b1, OFF_EXT_EN, 32'h17);
    fire(11'h500);
    expect_none(6);
    apb(1'b0, OFF_WDT_CTRL, 32'h0);
    chk(rd_v[WC_WDT], 1'b1);
    apb(1'b0, OFF_EXT_FLAG, 32'h0);
    chk(rd_v[XF_DIV], 1'b1);
    apb(1'b1, OFF_WDT_CTRL, 32'h0);
    apb(1'b1, OFF_EXT_FLAG, 32'h0);
    apb(1'b1, OFF_EXT_EN, 32'h3F);
    apb(1'b1, OFF_PRIMARY_EN, 32'h0F);
    fire(11'h002);
    expect_none(8);
    apb(1'b1, OFF_PRIMARY_EN, 32'hCF);
    wait_vec(8'h0B);
    do_reti();
    blk_req <= 1'b1;
    fire(11'h008);
    expect_none(8);
    blk_req <= 1'b0;
    wait_vec(8'h1B);
    do_reti();
    instr_len <= 3'h1;
    apb(1'b1, OFF_PRIORITY, 32'h010);
    apb(1'b0, OFF_PRIORITY, 32'h0);
    chk(rd_v, 32'h0000_0010);
    fire(11'h01A);
    wait_vec(8'h3B);
    expect_none(5);
    chk(in_service_high, 1'b1);
    do_reti();
    wait_vec(8'h0B);
    fire(11'h010);
    wait_vec(8'h3B);
    do_reti();
    do_reti();
    wait_vec(8'h1B);
    expect_none(4);
    chk(in_service_low, 1'b1);
    // Status word: vector 1Bh in bits 9:2, low level in service
    apb(1'b0, OFF_STATUS, 32'h0);
    chk(rd_v, 32'h0000_006D);
    do_reti();
    apb(1'b1, OFF_TIMER_CTRL, 32'h00);
    pin_n <= 4'hE;
    wait_vec(8'h03);
    apb(1'b0, OFF_TIMER_CTRL, 32'h0);
    chk(rd_v[1], 1'b1);
    do_reti();
    wait_vec(8'h03);
    pin_n <= 4'hF;
    repeat (4) @(posedge pclk);
    do_reti();
    expect_none(6);
    blk_req <= 1'b1;
    pin_n <= 4'hD;
    expect_none(3);
    pin_n <= 4'hF;
    expect_none(4);
    blk_req <= 1'b0;
    expect_none(6);
    fire(11'h002);
    wait_vec(8'h0B);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk(in_service_low, 1'b0);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, OFF_PRIMARY_EN, 32'h0);
    chk(rd_v, 32'h0);
    summarize();
  end
endmodule // two_level_interrupt_controller_tb_top
